// >>> sfios_pkg.sv
package sfios_pkg;

  localparam logic [7:0] OP_READ_SCUR = 8'h2B;
  localparam logic [7:0] OP_WRITE_SCUR = 8'h2F;
  localparam logic [3:0] CMD_LAST_BIT = 4'h7;
  localparam logic [3:0] CMD_BITS = 4'h8;
  localparam logic [3:0] CNT_SAT = 4'h9;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [2:0] BIT_LSB = 3'h0;
  localparam logic [1:0] IDENT_FIRST_BYTE = 2'h0;
  localparam logic [1:0] IDENT_LAST_BYTE = 2'h2;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  typedef enum logic [1:0]
  {
    RESP_NONE = 2'b00,
    RESP_IDENT = 2'b01,
    RESP_SCUR = 2'b10
  } sfios_resp_type;

  // security_flags layout, bit 7 down to bit 0
  typedef struct packed
  {
    logic block_sel;
    logic erase_fail;
    logic prog_fail;
    logic stream_prog;
    logic rsvd3;
    logic rsvd2;
    logic lockdown;
    logic factory_lock;
  } sfios_flags_type;

  // nonvolatile bits as held by the array
  typedef struct packed
  {
    logic factory_lock;
    logic lockdown;
    logic block_sel;
  } sfios_nv_type;

  // reports from the rest of the device, on core_clk
  typedef struct packed
  {
    logic prog_pass;
    logic prog_fail;
    logic erase_pass;
    logic erase_fail;
    logic block_sel_set;
    logic stream_active;
  } sfios_events_type;

  typedef struct packed
  {
    logic otp_mode;
    logic array_allowed;
    logic otp_writable;
    logic cfg_cmds_allowed;
    logic all_blocks_protected;
    logic locks_preset;
    logic wel_clear;
    logic lockdown_program;
  } sfios_ctrl_type;

endpackage

// >>> sfios_top.sv
`timescale 1ns/1ps

module sfios_top #(
  parameter logic [7:0] OP_READ_IDENT = 8'hA1,
  parameter logic [7:0] OP_ENTER_OTP = 8'hA2,
  parameter logic [7:0] OP_EXIT_OTP = 8'hA3,
  parameter logic [7:0] ID_MAKER = 8'h5A, // arbitrary value
  parameter logic [7:0] ID_TYPE = 8'h3C, // arbitrary value
  parameter logic [7:0] ID_DENSITY = 8'h16 // arbitrary value
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic wel_in,
  input wire sfios_pkg::sfios_nv_type nv_in,
  input wire sfios_pkg::sfios_events_type ev_in,
  output logic so,
  output logic so_oe,
  output sfios_pkg::sfios_ctrl_type ctrl_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // state types

  typedef struct packed
  {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic wp_s1;
    logic wp_s2;
    logic frm_s1;
    logic frm_s2;
    logic frm_seen;
    logic ack_s1;
    logic ack_s2;
    logic req_tgl;
    logic loaded;
    logic otp_mode;
    sfios_pkg::sfios_flags_type flags;
    logic [7:0] shadow;
    sfios_pkg::sfios_ctrl_type ctrl;
  } sfios_core_type;
  typedef struct packed
  {
    logic [3:0] cnt;
    logic [6:0] shift;
    sfios_pkg::sfios_resp_type resp;
  } sfios_frame_type;
  typedef struct packed
  {
    logic [7:0] frame_cmd;
    logic exact;
    logic frame_tgl;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic [7:0] scur_copy;
  } sfios_hold_type;
  typedef struct packed
  {
    logic so;
    logic so_oe;
    logic [2:0] bitpos;
    logic [1:0] bytesel;
  } sfios_out_type;

  sfios_core_type c_reg;
  sfios_core_type c_next;
  sfios_frame_type f_reg;
  sfios_frame_type f_next;
  sfios_hold_type h_reg;
  sfios_hold_type h_next;
  sfios_out_type o_reg;
  sfios_out_type o_next;
  logic link_rst_n;
  logic cs_rise;
  logic new_frame;
  logic [7:0] opcode;
  logic [7:0] out_byte;

  // frame logic is held in reset while deselected
  assign link_rst_n = arst_n & ~cs_n;

  ////////////////////////////////////////////////////////////////////////////////
  // link side, rising sclk: opcode capture

  always_comb
  begin
    f_next = f_reg;
    h_next = h_reg;
    opcode = {f_reg.shift, si};
    f_next.cnt = (f_reg.cnt < sfios_pkg::CNT_SAT) ? f_reg.cnt + 4'h1 : f_reg.cnt;
    f_next.shift = (f_reg.cnt < sfios_pkg::CMD_LAST_BIT) ? opcode[6:0] : f_reg.shift;
    h_next.frame_tgl = h_reg.frame_tgl ^ (f_reg.cnt == 4'h0);
    // set only by the eighth edge, so a ninth edge clears it again
    h_next.exact = f_reg.cnt == sfios_pkg::CMD_LAST_BIT;
    if (f_reg.cnt == sfios_pkg::CMD_LAST_BIT)
    begin
      h_next.frame_cmd = opcode;
      if (opcode == OP_READ_IDENT)
      begin
        f_next.resp = sfios_pkg::RESP_IDENT;
      end
      else if (opcode == sfios_pkg::OP_READ_SCUR)
      begin
        f_next.resp = sfios_pkg::RESP_SCUR;
      end
      else
      begin
        f_next.resp = sfios_pkg::RESP_NONE;
      end
    end
    // register value arrives by toggle handshake
    h_next.req_s1 = c_reg.req_tgl;
    h_next.req_s2 = h_reg.req_s1;
    if (h_reg.req_s2 != h_reg.req_seen)
    begin
      h_next.scur_copy = c_reg.shadow;
      h_next.req_seen = h_reg.req_s2;
    end
  end

  always_ff @(posedge sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      f_reg <= '0;
    end
    else
    begin
      f_reg <= f_next;
    end
  end

  always_ff @(posedge sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      h_reg <= '0;
    end
    else
    begin
      h_reg <= h_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link side, falling sclk: response shifter

  always_comb
  begin
    o_next = o_reg;
    unique case (o_reg.bytesel)
      2'h0: out_byte = ID_MAKER;
      2'h1: out_byte = ID_TYPE;
      default: out_byte = ID_DENSITY;
    endcase
    if (f_reg.resp == sfios_pkg::RESP_SCUR)
    begin
      out_byte = h_reg.scur_copy;
    end
    if (f_reg.cnt >= sfios_pkg::CMD_BITS && f_reg.resp != sfios_pkg::RESP_NONE)
    begin
      o_next.so_oe = 1'b1;
      o_next.so = out_byte[o_reg.bitpos];
      o_next.bitpos = o_reg.bitpos - 3'h1;
      if (o_reg.bitpos == sfios_pkg::BIT_LSB)
      begin
        o_next.bytesel = (o_reg.bytesel == sfios_pkg::IDENT_LAST_BYTE)
                         ? sfios_pkg::IDENT_FIRST_BYTE : o_reg.bytesel + 2'h1;
      end
    end
  end

  always_ff @(negedge sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      o_reg <= '{so: 1'b0, so_oe: 1'b0, bitpos: sfios_pkg::BIT_MSB,
                 bytesel: sfios_pkg::IDENT_FIRST_BYTE};
    end
    else
    begin
      o_reg <= o_next;
    end
  end

  assign so = o_reg.so;
  assign so_oe = o_reg.so_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // core side: mode, security flags, outputs

  assign cs_rise = c_reg.cs_s2 & ~c_reg.cs_s3;
  assign new_frame = c_reg.frm_s2 != c_reg.frm_seen;

  always_comb
  begin
    c_next = c_reg;
    c_next.cs_s1 = cs_n;
    c_next.cs_s2 = c_reg.cs_s1;
    c_next.cs_s3 = c_reg.cs_s2;
    c_next.wp_s1 = wp_n;
    c_next.wp_s2 = c_reg.wp_s1;
    c_next.frm_s1 = h_reg.frame_tgl;
    c_next.frm_s2 = c_reg.frm_s1;
    c_next.ack_s1 = h_reg.req_seen;
    c_next.ack_s2 = c_reg.ack_s1;
    c_next.ctrl.wel_clear = 1'b0;
    c_next.ctrl.lockdown_program = 1'b0;
    c_next.ctrl.locks_preset = 1'b0;
    if (!c_reg.loaded)
    begin
      c_next.loaded = 1'b1;
      c_next.flags.factory_lock = nv_in.factory_lock;
      c_next.flags.lockdown = nv_in.lockdown;
      c_next.flags.block_sel = nv_in.block_sel;
      c_next.ctrl.locks_preset = nv_in.block_sel;
    end
    // frame end: chip select frozen link registers are stable here
    if (cs_rise && new_frame)
    begin
      c_next.frm_seen = c_reg.frm_s2;
      if (h_reg.exact)
      begin
        if (h_reg.frame_cmd == OP_ENTER_OTP || h_reg.frame_cmd == OP_EXIT_OTP)
        begin
          c_next.otp_mode = h_reg.frame_cmd == OP_ENTER_OTP;
        end
        else if (h_reg.frame_cmd == sfios_pkg::OP_WRITE_SCUR && wel_in && !c_reg.otp_mode
                 && !c_reg.flags.lockdown)
        begin
          c_next.flags.lockdown = 1'b1;
          c_next.ctrl.lockdown_program = 1'b1;
          c_next.ctrl.wel_clear = 1'b1;
        end
      end
    end
    // block select is one-way; refused in otp mode
    c_next.flags.block_sel = c_next.flags.block_sel
                             | (ev_in.block_sel_set & ~c_reg.otp_mode);
    // failure wins over a same-cycle success
    c_next.flags.prog_fail = ev_in.prog_fail
                             | (c_reg.flags.prog_fail & ~ev_in.prog_pass);
    c_next.flags.erase_fail = ev_in.erase_fail
                              | (c_reg.flags.erase_fail & ~ev_in.erase_pass);
    c_next.flags.stream_prog = ev_in.stream_active;
    c_next.flags.rsvd3 = 1'b0;
    c_next.flags.rsvd2 = 1'b0;
    if (c_reg.ack_s2 == c_reg.req_tgl && c_reg.shadow != c_reg.flags)
    begin
      c_next.shadow = c_reg.flags;
      c_next.req_tgl = ~c_reg.req_tgl;
    end
    c_next.ctrl.otp_mode = c_next.otp_mode;
    c_next.ctrl.array_allowed = ~c_next.otp_mode;
    c_next.ctrl.otp_writable = c_next.otp_mode & ~c_next.flags.lockdown;
    c_next.ctrl.cfg_cmds_allowed = ~c_next.otp_mode;
    c_next.ctrl.all_blocks_protected = c_next.flags.block_sel & ~c_reg.wp_s2;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // pins idle high, so no false chip select or protect edge after reset
      c_reg <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, wp_s1: 1'b1, wp_s2: 1'b1,
                 flags: sfios_pkg::FLAGS_RESET, shadow: sfios_pkg::FLAGS_RESET, default: '0};
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  assign ctrl_out = c_reg.ctrl;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  chk_otp_enter: assert property (@(posedge core_clk) disable iff (!arst_n)
    cs_rise && new_frame && h_reg.exact && h_reg.frame_cmd == OP_ENTER_OTP
    |=> ctrl_out.otp_mode && !ctrl_out.array_allowed)
    else $error("enter otp not taken");
  chk_otp_exit: assert property (@(posedge core_clk) disable iff (!arst_n)
    cs_rise && new_frame && h_reg.exact && h_reg.frame_cmd == OP_EXIT_OTP
    |=> !ctrl_out.otp_mode && ctrl_out.array_allowed)
    else $error("exit otp not taken");
  chk_array_blocked: assert property (@(posedge core_clk) disable iff (!arst_n)
    c_reg.otp_mode |-> !ctrl_out.array_allowed && !ctrl_out.cfg_cmds_allowed)
    else $error("array reachable in otp mode");
  chk_otp_locked_ro: assert property (@(posedge core_clk) disable iff (!arst_n)
    c_reg.flags.lockdown |-> !ctrl_out.otp_writable)
    else $error("locked otp writable");
  chk_lockdown_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    c_reg.loaded && $past(c_reg.loaded) && $past(c_reg.flags.lockdown)
    |-> c_reg.flags.lockdown)
    else $error("lockdown bit cleared");
  chk_write_security_reg_cause: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(c_reg.flags.lockdown) && $past(c_reg.loaded)
    |-> $past(wel_in) && !$past(c_reg.otp_mode) && ctrl_out.wel_clear
        && ctrl_out.lockdown_program)
    else $error("lockdown set without cause");
  chk_wel_once: assert property (@(posedge core_clk) disable iff (!arst_n)
    ctrl_out.wel_clear |=> !ctrl_out.wel_clear)
    else $error("wel clear not a pulse");
  chk_pfail_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    ev_in.prog_fail |=> c_reg.flags.prog_fail)
    else $error("program fail not flagged");
  chk_pfail_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    ev_in.prog_pass && !ev_in.prog_fail |=> !c_reg.flags.prog_fail)
    else $error("program fail not cleared");
  chk_efail_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
    ev_in.erase_fail ##1 (!ev_in.erase_pass)[*2] |-> c_reg.flags.erase_fail)
    else $error("erase fail lost");
  chk_blksel_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    c_reg.loaded && c_reg.flags.block_sel |=> c_reg.flags.block_sel)
    else $error("block select cleared");
  chk_wp_protect: assert property (@(posedge core_clk) disable iff (!arst_n)
    c_reg.flags.block_sel && !c_reg.wp_s2 |=> ctrl_out.all_blocks_protected)
    else $error("wp low did not protect");
  chk_so_start: assert property (@(negedge sclk) disable iff (!link_rst_n)
    f_reg.cnt == sfios_pkg::CMD_BITS && f_reg.resp != sfios_pkg::RESP_NONE |=> so_oe)
    else $error("response not started");
  cov_otp_entry: cover property (@(posedge core_clk) disable iff (!arst_n)
    $rose(c_reg.otp_mode));
  cov_lockdown: cover property (@(posedge core_clk) disable iff (!arst_n)
    $rose(c_reg.flags.lockdown) && c_reg.loaded);
  cov_pfail: cover property (@(posedge core_clk) disable iff (!arst_n)
    $rose(c_reg.flags.prog_fail));
  cov_scur_read: cover property (@(negedge sclk) disable iff (!link_rst_n)
    so_oe && f_reg.resp == sfios_pkg::RESP_SCUR);

endmodule // sfios_top

// >>> sfios_host_model.sv
`timescale 1ns/1ps

module sfios_host_model
(
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one frame: nb opcode bits then rb read bits; sclk idles low between frames
  task automatic xfer(input logic [7:0] op, input int nb, input int rb,
                      output logic [31:0] rd);
    rd = 32'h0000_0000;
    #3.1;
    cs_n = 1'b0;
    for (int i = 0; i < nb + rb; i++)
    begin
      si = (i < 8) ? op[7 - i] : ~si;
      #7.5;
      sclk = 1'b1;
      if (i >= nb)
      begin
        rd = {rd[30:0], so};
      end
      #7.5;
      sclk = 1'b0;
    end
    #7.5;
    cs_n = 1'b1;
    si = ~si;
    #60;
  endtask

endmodule // sfios_host_model

// >>> testbench.sv
`timescale 1ns/1ps

module testbench;

  localparam logic [7:0] OP_ID = 8'hA1;
  localparam logic [7:0] OP_EN = 8'hA2;
  localparam logic [7:0] OP_EX = 8'hA3;
  localparam logic [7:0] ID_M = 8'h5A; // arbitrary value
  localparam logic [7:0] ID_T = 8'h3C; // arbitrary value
  localparam logic [7:0] ID_D = 8'h16; // arbitrary value

  logic core_clk;
  logic arst_n;
  logic wp_n;
  logic wel_in;
  sfios_pkg::sfios_nv_type nv_in;
  sfios_pkg::sfios_events_type ev_in;
  logic so;
  logic so_oe;
  sfios_pkg::sfios_ctrl_type ctrl_out;
  logic sclk;
  logic cs_n;
  logic si;
  logic so_pin;
  logic [31:0] d;
  int fail_count;
  int total_checks;
  int cyc;
  int wel_cnt;
  int lp_cnt;
  int pre_cnt;

  sfios_top #(.OP_READ_IDENT(OP_ID), .OP_ENTER_OTP(OP_EN), .OP_EXIT_OTP(OP_EX),
    .ID_MAKER(ID_M), .ID_TYPE(ID_T), .ID_DENSITY(ID_D)) i_dut
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .si(si),
    .wp_n(wp_n),
    .wel_in(wel_in),
    .nv_in(nv_in),
    .ev_in(ev_in),
    .so(so),
    .so_oe(so_oe),
    .ctrl_out(ctrl_out)
  );

  sfios_host_model i_host
  (
    .sclk(sclk),
    .cs_n(cs_n),
    .si(si),
    .so(so_pin)
  );

  // deselected output shows the inverse of so, which reset holds low, so it reads high
  assign so_pin = so_oe ? so : ~so;

  initial
  begin
    core_clk = 1'b0;
    forever
    begin
      #5 core_clk = ~core_clk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pulse counters and hang guard
  always @(posedge core_clk)
  begin
    wel_cnt <= wel_cnt + ((ctrl_out.wel_clear === 1'b1) ? 1 : 0);
    lp_cnt <= lp_cnt + ((ctrl_out.lockdown_program === 1'b1) ? 1 : 0);
    pre_cnt <= pre_cnt + ((ctrl_out.locks_preset === 1'b1) ? 1 : 0);
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude;
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input int nb);
    i_host.xfer(op, nb, 0, d);
    repeat (8) @(posedge core_clk);
  endtask

  // first read lets the value cross, second is compared
  task automatic rd_sec(input logic [7:0] e);
    i_host.xfer(sfios_pkg::OP_READ_SCUR, 8, 8, d);
    i_host.xfer(sfios_pkg::OP_READ_SCUR, 8, 16, d);
    check(d, {16'h0000, e, e});
  endtask

  task automatic ev(input logic [5:0] e);
    @(posedge core_clk);
    ev_in <= sfios_pkg::sfios_events_type'(e);
    @(posedge core_clk);
    ev_in <= sfios_pkg::sfios_events_type'(6'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    arst_n = 1'b0;
    wp_n = 1'b1;
    wel_in = 1'b0;
    nv_in = sfios_pkg::sfios_nv_type'(3'h4);
    ev_in = sfios_pkg::sfios_events_type'(6'h00);
    {fail_count, total_checks, cyc, wel_cnt, lp_cnt, pre_cnt} = '0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(ctrl_out[7:4], 32'h5);
    rd_sec(8'h01);
    i_host.xfer(OP_ID, 8, 32, d);
    check(d, {ID_M, ID_T, ID_D, ID_M});
    check({so_oe, so}, 32'h0);
    ev(6'h10);
    ev(6'h10);
    rd_sec(8'h21);
    ev(6'h30);
    rd_sec(8'h21);
    ev(6'h20);
    rd_sec(8'h01);
    ev(6'h04);
    rd_sec(8'h41);
    ev(6'h08);
    rd_sec(8'h01);
    @(posedge core_clk);
    ev_in <= sfios_pkg::sfios_events_type'(6'h01);
    rd_sec(8'h11);
    @(posedge core_clk);
    ev_in <= sfios_pkg::sfios_events_type'(6'h00);
    rd_sec(8'h01);
    cmd(sfios_pkg::OP_WRITE_SCUR, 8);
    rd_sec(8'h01);
    @(posedge core_clk);
    wel_in <= 1'b1;
    cmd(sfios_pkg::OP_WRITE_SCUR, 9);
    rd_sec(8'h01);
    cmd(OP_EN, 8);
    check(ctrl_out[7:4], 32'hA);
    cmd(sfios_pkg::OP_WRITE_SCUR, 8);
    ev(6'h02);
    rd_sec(8'h01);
    check(wel_cnt, 32'h0);
    cmd(OP_EX, 9);
    check(ctrl_out[7:4], 32'hA);
    cmd(OP_EX, 8);
    check(ctrl_out[7:4], 32'h5);
    cmd(sfios_pkg::OP_WRITE_SCUR, 8);
    check(wel_cnt, 32'h1);
    check(lp_cnt, 32'h1);
    rd_sec(8'h03);
    cmd(sfios_pkg::OP_WRITE_SCUR, 8);
    check(lp_cnt, 32'h1);
    cmd(OP_EN, 8);
    check(ctrl_out[7:4], 32'h8);
    cmd(OP_EX, 8);
    ev(6'h02);
    rd_sec(8'h83);
    @(posedge core_clk);
    wp_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(ctrl_out.all_blocks_protected, 32'h1);
    wp_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    check(ctrl_out.all_blocks_protected, 32'h0);
    arst_n <= 1'b0;
    nv_in <= sfios_pkg::sfios_nv_type'(3'h3);
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(pre_cnt, 32'h1);
    rd_sec(8'h82);
    conclude();
  end

endmodule // testbench
